// ===== spi_status_data_baud.sv
// Purpose: status, data buffer and baud divisor of the serial unit
// Assumes: slave select, sck and data inputs synchronous to clk
// Notes: mode 0 framing only (sample rising, launch falling)
//
// The address-and-strobe port was left to the implementer.
`include "spi_cfg.svh"
module spi_status_data_baud
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic irq,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_n_in,
	output logic ss_n_out,
	output logic ss_n_oe
);
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ctrl1_ff, nxt_ctrl1;
	logic [7:0] ctrl2_ff, nxt_ctrl2;
	logic [7:0] baud_ff, nxt_baud;
	logic rx_full_ff, nxt_rx_full;
	logic tx_empty_ff, nxt_tx_empty;
	logic fault_ff, nxt_fault;
	logic rx_armed_ff, nxt_rx_armed;
	logic tx_armed_ff, nxt_tx_armed;
	logic fault_armed_ff, nxt_fault_armed;
	logic [7:0] rx_data_ff, nxt_rx_data;
	logic [7:0] tx_data_ff, nxt_tx_data;
	logic [2:0] irq_stat_ff, nxt_irq_stat;
	logic [2:0] irq_mask_ff, nxt_irq_mask;
	logic [7:0] nxt_rdata;
	logic nxt_irq;
	logic ss_n_d_ff, sck_d_ff;
	spi_pkg::xfer_state_t state_ff, nxt_state;
	logic [3:0] bits_ff, nxt_bits;
	logic sck_ff, nxt_sck;
	logic ss_drive_ff, nxt_ss_drive;
	logic restart, half_tick, load, sample, shift, done;
	logic [7:0] shreg;
	logic shout;
	logic master, enable, fault_event, slave_abort, baud_change;
	logic [7:0] status;

	assign master = ctrl1_ff[`BIT_MASTER];
	assign enable = ctrl1_ff[`BIT_ENABLE];
	assign status = {rx_full_ff, 1'b0, tx_empty_ff, fault_ff, 4'h0};
	assign fault_event = enable && master && ctrl2_ff[`BIT_FAULT_EN]
		&& ss_n_d_ff && !ss_n_in; // RULE9
	assign slave_abort = !master && ss_n_in && state_ff != spi_pkg::ST_IDLE;
	assign baud_change = wr && addr == `ADDR_BAUD
		&& {wdata[6:4], wdata[2:0]} != {baud_ff[6:4], baud_ff[2:0]};

	baud_divider u_div
	(
		.clk(clk),
		.rstn(rstn),
		.restart(restart),
		.baud_preselect(baud_ff[6:4]),
		.baud_select(baud_ff[2:0]),
		.half_tick(half_tick)
	);

	shift_core u_shift
	(
		.clk(clk),
		.rstn(rstn),
		.load(load),
		.load_data(tx_data_ff),
		.sample(sample),
		.shift(shift),
		.din(master ? miso_in : mosi_in),
		.shreg(shreg),
		.dout(shout)
	);

	// ****************************************
	// transfer engine
	// ****************************************
	// slave mode relies on the master staying below divide-by-two
	always_comb
	begin
		nxt_state = state_ff;
		nxt_bits = bits_ff;
		nxt_sck = sck_ff;
		nxt_ss_drive = ss_drive_ff;
		restart = 1'b0;
		load = 1'b0;
		sample = 1'b0;
		shift = 1'b0;
		done = 1'b0;
		case (state_ff)
			spi_pkg::ST_IDLE:
			begin
				nxt_sck = 1'b0;
				nxt_ss_drive = 1'b0;
				if (enable && !tx_empty_ff && master && !fault_event)
				begin
					load = 1'b1; // RULE12
					restart = 1'b1;
					nxt_ss_drive = 1'b1;
					nxt_bits = 4'h0;
					nxt_state = spi_pkg::ST_LEAD;
				end
				else if (enable && !master && !ss_n_in)
				begin
					load = 1'b1;
					nxt_bits = 4'h0;
					nxt_state = spi_pkg::ST_SHIFT;
				end
			end
			spi_pkg::ST_LEAD:
				if (half_tick) // half sck period lead-in
					nxt_state = spi_pkg::ST_SHIFT;
			spi_pkg::ST_SHIFT:
				if (master)
				begin
					if (half_tick)
					begin
						nxt_sck = !sck_ff;
						if (!sck_ff)
							sample = 1'b1;
						else
						begin
							shift = 1'b1;
							nxt_bits = bits_ff + 4'h1;
						end
					end
				end
				else
				begin
					if (sck_in && !sck_d_ff)
						sample = 1'b1;
					if (!sck_in && sck_d_ff)
					begin
						shift = 1'b1;
						nxt_bits = bits_ff + 4'h1;
					end
				end
			default:
				nxt_state = spi_pkg::ST_IDLE;
		endcase
		if (shift && bits_ff == `BITS_PER_FRAME - 4'h1)
		begin
			done = 1'b1;
			nxt_state = spi_pkg::ST_IDLE;
		end
		if (fault_event || slave_abort || (master && baud_change) || !enable)
		begin
			nxt_state = spi_pkg::ST_IDLE; // RULE17
			nxt_sck = 1'b0;
			nxt_ss_drive = 1'b0;
			done = 1'b0;
		end
	end

	// ****************************************
	// registers and flags
	// ****************************************
	always_comb
	begin
		nxt_ctrl1 = ctrl1_ff;
		nxt_ctrl2 = ctrl2_ff;
		nxt_baud = baud_ff;
		nxt_rx_full = rx_full_ff;
		nxt_tx_empty = tx_empty_ff;
		nxt_fault = fault_ff;
		nxt_rx_armed = rx_armed_ff;
		nxt_tx_armed = tx_armed_ff;
		nxt_fault_armed = fault_armed_ff;
		nxt_rx_data = rx_data_ff;
		nxt_tx_data = tx_data_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_irq_stat = irq_stat_ff;
		nxt_rdata = 8'h00;
		if (rd)
		begin
			case (addr)
				`ADDR_CTRL1: nxt_rdata = ctrl1_ff;
				`ADDR_CTRL2: nxt_rdata = ctrl2_ff;
				`ADDR_BAUD: nxt_rdata = {1'b0, baud_ff[6:4], 1'b0, baud_ff[2:0]};
				`ADDR_STATUS: nxt_rdata = status; // RULE3
				`ADDR_IRQ_STAT: nxt_rdata = {5'h00, irq_stat_ff};
				`ADDR_DATA: nxt_rdata = rx_data_ff; // RULE11 RULE13
				`ADDR_IRQ_MASK: nxt_rdata = {5'h00, irq_mask_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
		if (rd && addr == `ADDR_STATUS)
		begin
			nxt_rx_armed = rx_full_ff;
			nxt_tx_armed = tx_empty_ff;
			nxt_fault_armed = fault_ff;
		end
		if (rd && addr == `ADDR_DATA && rx_armed_ff)
		begin
			nxt_rx_full = 1'b0; // RULE5
			nxt_rx_armed = 1'b0;
		end
		if (wr && addr == `ADDR_DATA)
		begin
			if (tx_armed_ff)
			begin
				nxt_tx_data = wdata; // RULE7
				nxt_tx_empty = 1'b0; // RULE6
			end
			nxt_tx_armed = 1'b0; // RULE8
		end
		if (wr && addr == `ADDR_CTRL1)
		begin
			nxt_ctrl1 = wdata;
			if (fault_armed_ff)
				nxt_fault = 1'b0; // RULE10
			nxt_fault_armed = 1'b0;
		end
		if (wr && addr == `ADDR_CTRL2)
			nxt_ctrl2 = wdata;
		if (wr && addr == `ADDR_BAUD)
			nxt_baud = {1'b0, wdata[6:4], 1'b0, wdata[2:0]};
		if (wr && addr == `ADDR_IRQ_MASK)
			nxt_irq_mask = wdata[2:0];
		if (wr && addr == `ADDR_IRQ_STAT)
			nxt_irq_stat = irq_stat_ff & ~wdata[2:0];
		if (load)
			nxt_tx_empty = 1'b1; // RULE6
		if (done && !rx_full_ff)
		begin
			nxt_rx_data = {shreg[6:0], u_shift.sample_ff}; // RULE4
			nxt_rx_full = 1'b1; // RULE4
		end
		// later bytes are dropped so the first stays readable
		if (done && rx_full_ff)
			nxt_rx_data = rx_data_ff; // RULE14
		if (fault_event)
		begin
			nxt_fault = 1'b1; // RULE9
			nxt_ctrl1[`BIT_MASTER] = 1'b0; // RULE17
		end
		// set wins over clear
		nxt_irq_stat = nxt_irq_stat | {fault_event, load, done && !rx_full_ff};
		nxt_irq = ((nxt_irq_stat & nxt_irq_mask) != 3'h0)
			|| (nxt_ctrl1[`BIT_IRQ_EN] && (nxt_rx_full || nxt_fault)); // RULE16
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl1_ff <= `CTRL1_RESET;
			ctrl2_ff <= `CTRL2_RESET;
			baud_ff <= `BAUD_RESET;
			rx_full_ff <= 1'b0; // RULE18
			tx_empty_ff <= 1'b1; // RULE18
			fault_ff <= 1'b0; // RULE18
			rx_armed_ff <= 1'b0;
			tx_armed_ff <= 1'b0;
			fault_armed_ff <= 1'b0;
			rx_data_ff <= 8'h00;
			tx_data_ff <= 8'h00;
			irq_stat_ff <= 3'h0;
			irq_mask_ff <= 3'h0;
			rdata <= 8'h00;
			irq <= 1'b0;
			ss_n_d_ff <= 1'b1;
			sck_d_ff <= 1'b0;
			state_ff <= spi_pkg::ST_IDLE;
			bits_ff <= 4'h0;
			sck_ff <= 1'b0;
			ss_drive_ff <= 1'b0;
		end
		else
		begin
			ctrl1_ff <= nxt_ctrl1;
			ctrl2_ff <= nxt_ctrl2;
			baud_ff <= nxt_baud;
			rx_full_ff <= nxt_rx_full;
			tx_empty_ff <= nxt_tx_empty;
			fault_ff <= nxt_fault;
			rx_armed_ff <= nxt_rx_armed;
			tx_armed_ff <= nxt_tx_armed;
			fault_armed_ff <= nxt_fault_armed;
			rx_data_ff <= nxt_rx_data;
			tx_data_ff <= nxt_tx_data;
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
			rdata <= nxt_rdata;
			irq <= nxt_irq;
			ss_n_d_ff <= ss_n_in;
			sck_d_ff <= sck_in;
			state_ff <= nxt_state;
			bits_ff <= nxt_bits;
			sck_ff <= nxt_sck;
			ss_drive_ff <= nxt_ss_drive;
		end
	end

	// ****************************************
	// pins
	// ****************************************
	logic mout_ff, moe_ff, sout_ff, soe_ff, ckoe_ff, ssoe_ff, ssout_ff;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mout_ff <= 1'b0;
			moe_ff <= 1'b0;
			sout_ff <= 1'b0;
			soe_ff <= 1'b0;
			ckoe_ff <= 1'b0;
			ssoe_ff <= 1'b0;
			ssout_ff <= 1'b1;
		end
		else
		begin
			// fault drops master at once, releasing every output
			mout_ff <= shout;
			moe_ff <= enable && nxt_ctrl1[`BIT_MASTER]; // RULE17
			sout_ff <= shout;
			soe_ff <= enable && !nxt_ctrl1[`BIT_MASTER] && !ss_n_in && !nxt_fault; // RULE17
			ckoe_ff <= enable && nxt_ctrl1[`BIT_MASTER];
			ssoe_ff <= enable && nxt_ctrl1[`BIT_MASTER] && !ctrl2_ff[`BIT_FAULT_EN];
			ssout_ff <= !nxt_ss_drive;
		end
	end
	assign mosi_out = mout_ff;
	assign mosi_oe = moe_ff;
	assign miso_out = sout_ff;
	assign miso_oe = soe_ff;
	assign sck_out = sck_ff;
	assign sck_oe = ckoe_ff;
	assign ss_n_out = ssout_ff;
	assign ss_n_oe = ssoe_ff;
endmodule : spi_status_data_baud

// ===== spi_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the serial unit
// Assumes: one 50 MHz clock, byte registers on a plain strobe port
// Notes: included by its bare name
//
// Summary of operation
// RULE1: serial clock is bus clock over selected divisor
// RULE2: slave link never clocked at divide-by-two
// RULE3: status readable anytime, writes change nothing
// RULE4: receive flag sets when byte reaches data
// RULE5: receive flag clears: status read, data read
// RULE6: transmit-empty flag high while buffer empty
// RULE7: status read then data write queues byte
// RULE8: data write without armed status read dropped
// RULE9: slave select low as master sets fault
// RULE10: fault clears: status read, control write
// RULE11: one data address reads rx, writes tx
// RULE12: master starts queued byte right after previous
// RULE13: received byte valid until next transfer ends
// RULE14: unserviced later bytes lost, first byte kept
// RULE15: divisor is (pre+1) times two^(sel+1)
// RULE16: fault with interrupt enable requests interrupt
// RULE17: fault clears master, releases outputs, aborts
// RULE18: reset: tx empty set, other flags clear
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH
`define ADDR_CTRL1 3'h0
`define ADDR_CTRL2 3'h1
`define ADDR_BAUD 3'h2
`define ADDR_STATUS 3'h3
`define ADDR_IRQ_STAT 3'h4
`define ADDR_DATA 3'h5
`define ADDR_IRQ_MASK 3'h6
`define BIT_RX_FULL 7
`define BIT_TX_EMPTY 5
`define BIT_FAULT 4
`define BIT_IRQ_EN 7
`define BIT_ENABLE 6
`define BIT_MASTER 4
`define BIT_FAULT_EN 4
`define CTRL1_RESET 8'h04
`define CTRL2_RESET 8'h00
`define BAUD_RESET 8'h00
`define STATUS_RESET 8'h20
`define BITS_PER_FRAME 4'h8
`endif

// ===== spi_pkg.sv
// Purpose: types shared by the serial unit
// Assumes: nothing
// Notes: states in binary
package spi_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_SHIFT = 2'b10
	} xfer_state_t;
endpackage : spi_pkg

// ===== baud_divider.sv
// Purpose: half-period tick generator for the serial clock
// Assumes: restart pulses at frame start
// Notes: tick every divisor/2 cycles
`include "spi_cfg.svh"
module baud_divider
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic restart,
	input wire logic [2:0] baud_preselect,
	input wire logic [2:0] baud_select,
	output logic half_tick
);
	// ****************************************
	// divisor
	// ****************************************
	logic [10:0] half_div;
	logic [10:0] cnt_ff;
	logic [10:0] nxt_cnt;
	logic nxt_half_tick;
	logic [3:0] pre_plus;
	always_comb
	begin
		pre_plus = {1'b0, baud_preselect} + 4'h1;
		half_div = 11'(pre_plus) << baud_select; // RULE15 RULE1
		nxt_half_tick = 1'b0;
		nxt_cnt = cnt_ff + 11'h001;
		if (restart)
			nxt_cnt = 11'h000;
		else if (cnt_ff >= half_div - 11'h001)
		begin
			nxt_cnt = 11'h000;
			nxt_half_tick = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_ff <= 11'h000;
			half_tick <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			half_tick <= nxt_half_tick;
		end
	end
endmodule : baud_divider

// ===== shift_core.sv
// Purpose: eight-bit shifter with sample and launch steps
// Assumes: caller orders sample before launch per bit
// Notes: msb first
`include "spi_cfg.svh"
module shift_core
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [7:0] load_data,
	input wire logic sample,
	input wire logic shift,
	input wire logic din,
	output logic [7:0] shreg,
	output logic dout
);
	logic sample_ff;
	logic nxt_sample;
	logic [7:0] nxt_shreg;
	always_comb
	begin
		nxt_shreg = shreg;
		nxt_sample = sample ? din : sample_ff;
		if (load)
			nxt_shreg = load_data;
		else if (shift)
			nxt_shreg = {shreg[6:0], sample_ff};
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			shreg <= 8'h00;
			sample_ff <= 1'b0;
		end
		else
		begin
			shreg <= nxt_shreg;
			sample_ff <= nxt_sample;
		end
	end
	assign dout = shreg[7];
endmodule : shift_core

// ===== spi_sdb_sva.sv
// Purpose: port checker for the serial unit
// Assumes: one clock domain
// Notes: bound after endmodule
`include "spi_cfg.svh"
module spi_sdb_sva
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic ss_n_out,
	input wire logic ss_n_oe
);
	// ****
	// helper state
	// ****
	logic ien_ff, sck_ff, fr_ff, have_ff, drd_ff, sel, rise, srd;
	logic [7:0] baud_ff, last_ff;
	logic [11:0] gap_ff, div;
	logic [4:0] cnt_ff;
	assign sel = ss_n_oe && !ss_n_out;
	assign rise = sck_out && !sck_ff;
	assign srd = rd && addr == `ADDR_STATUS;
	// divisor rebuilt from writes, never from the design
	assign div = ({9'h000, baud_ff[6:4]} + 12'h001) << ({1'b0, baud_ff[2:0]} + 4'h1);
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			{ien_ff, sck_ff, fr_ff, have_ff, drd_ff} <= 5'h00;
			{baud_ff, last_ff} <= 16'h0000;
			gap_ff <= 12'h000;
			cnt_ff <= 5'h00;
		end
		else
		begin
			sck_ff <= sck_out;
			drd_ff <= rd && addr == `ADDR_DATA;
			gap_ff <= rise ? 12'h001 : gap_ff + 12'h001;
			// queued bytes follow with select held low, so count whole bytes
			cnt_ff <= sel ? cnt_ff + {4'h0, rise} : 5'h00;
			if (wr && addr == `ADDR_CTRL1)
				ien_ff <= wdata[`BIT_IRQ_EN];
			if (wr && addr == `ADDR_BAUD)
				baud_ff <= wdata;
			if (drd_ff)
				{have_ff, last_ff} <= {1'b1, rdata};
			fr_ff <= drd_ff ? 1'b0 : fr_ff | (cnt_ff != 5'h00 && !sel);
		end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ****
	// assertions
	// ****
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	a_status_write: assert property (srd ##2 (wr && addr == `ADDR_STATUS) ##3 srd
		|=> rdata == $past(rdata, 5)) else $error("status changed by write");
	a_irq_cause: assert property ($past(srd) && ien_ff && (rdata[7] || rdata[4]) |-> irq)
		else $error("flag with enable but no irq");
	a_fault_release: assert property ($past(srd) && rdata[4] |-> !sck_oe)
		else $error("clock driven after fault");
	a_frame_bits: assert property (sel ##1 !sel |-> cnt_ff[2:0] == 3'h0 && cnt_ff != 5'h00)
		else $error("frame not eight clocks");
	a_sck_period: assert property (rise && cnt_ff[2:0] != 3'h0 |-> gap_ff == div)
		else $error("clock period off divisor");
	a_sck_framed: assert property (rise |-> sel)
		else $error("clock outside frame");
	a_data_hold: assert property (drd_ff && have_ff && !fr_ff |-> rdata == last_ff)
		else $error("data changed without transfer");
	c_fault: cover property ($past(srd) && rdata[4]);
	c_rx: cover property ($past(srd) && rdata[7]);
	c_frame: cover property (sel ##1 !sel);
endmodule : spi_sdb_sva
bind spi_status_data_baud spi_sdb_sva u_spi_sdb_sva (.clk(clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sck_out(sck_out),
	.sck_oe(sck_oe), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe));

// ===== spi_peer_slave.sv
// Purpose: far-side slave that echoes the previous frame once per select, then sends zeros
// Assumes: mode 0, lines sampled on clk
// Notes: also measures the clock period
module spi_peer_slave
(
	input wire logic clk,
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel,
	output logic miso,
	output logic [7:0] got,
	output logic [11:0] per
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh = 8'h00;
	logic [11:0] cnt = 12'h000;
	logic sck_q = 1'b0;
	logic sel_q = 1'b0;
	initial
		{got, per} = {8'h3C, 12'h000};
	// released line flips, so a stale bit never passes
	assign miso = !sel ? !sh[7] : (sel_q ? sh[7] : got[7]);
	always @(posedge clk)
	begin
		sck_q <= sck;
		sel_q <= sel;
		cnt <= cnt + 12'h001;
		if (sel && !sel_q)
			sh <= got;
		if (sel && sck && !sck_q)
		begin
			got <= {got[6:0], mosi};
			per <= cnt;
			cnt <= 12'h001;
		end
		if (sel && sel_q && !sck && sck_q)
			sh <= {sh[6:0], 1'b0};
	end
endmodule : spi_peer_slave

// ===== spi_status_data_baud_tb.sv
// Purpose: register-level test of the serial unit
// Assumes: echo slave on the link
// Notes: one frame of echo latency
`include "spi_cfg.svh"
module spi_status_data_baud_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, wr, rd, ss_drv, irq, miso, sel, sck_out, sck_oe, mosi_out, mosi_oe;
	logic ss_n_out, ss_n_oe, miso_out, miso_oe;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, got, q, prev;
	logic [11:0] per;
	int err_count, comparisons, cyc;
	logic [7:0] bauds [3] = '{8'h47, 8'h70, 8'h77};
	logic [11:0] divs [3] = '{12'h500, 12'h010, 12'h800};
	assign sel = ss_n_oe && !ss_n_out;
	spi_status_data_baud u_spi_status_data_baud
	(
		.clk(clk),
		.rstn(rstn),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.irq(irq),
		.sck_in(sck_oe ? sck_out : 1'b0),
		.sck_out(sck_out),
		.sck_oe(sck_oe),
		.mosi_in(mosi_oe ? mosi_out : 1'b0),
		.mosi_out(mosi_out),
		.mosi_oe(mosi_oe),
		.miso_in(miso_oe ? miso_out : miso),
		.miso_out(miso_out),
		.miso_oe(miso_oe),
		.ss_n_in(ss_n_oe ? ss_n_out : ss_drv),
		.ss_n_out(ss_n_out),
		.ss_n_oe(ss_n_oe)
	);
	spi_peer_slave u_spi_peer_slave
	(
		.clk(clk),
		.sck(sck_out),
		.mosi(mosi_out),
		.sel(sel),
		.miso(miso),
		.got(got),
		.per(per)
	);
	// ****
	// clock, timeout and tasks
	// ****
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		rd_reg(a, q);
		chk({4'h0, q}, {4'h0, e});
	endtask : rd_chk
	// irq is registered, so allow its update edge
	task automatic irq_chk(input logic e);
		repeat (2) @(posedge clk);
		#1 chk({11'h000, irq}, {11'h000, e});
	endtask : irq_chk
	// ****
	// tests
	// ****
	initial
	begin
		{rstn, wr, rd, addr, wdata} = '0;
		ss_drv = 1'b1;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		wr_reg(`ADDR_DATA, 8'h11);
		rd_chk(`ADDR_STATUS, `STATUS_RESET);
		wr_reg(`ADDR_STATUS, 8'hFF);
		rd_chk(`ADDR_STATUS, 8'h20);
		$display("test reset done");
		wr_reg(`ADDR_BAUD, 8'h10);
		wr_reg(`ADDR_CTRL1, 8'h50);
		rd_reg(`ADDR_STATUS, q);
		wr_reg(`ADDR_DATA, 8'hA5);
		repeat (2) @(posedge clk);
		rd_reg(`ADDR_STATUS, q);
		wr_reg(`ADDR_DATA, 8'h5A);
		rd_chk(`ADDR_STATUS, 8'h00);
		// back-to-back frames keep select low, so only one release
		@(posedge ss_n_out);
		repeat (4) @(posedge clk);
		chk({4'h0, got}, 12'h05A);
		rd_chk(`ADDR_STATUS, 8'hA0);
		rd_chk(`ADDR_DATA, 8'h3C);
		rd_chk(`ADDR_DATA, 8'h3C);
		rd_chk(`ADDR_STATUS, 8'h20);
		$display("test queue and overrun done");
		prev = 8'h5A;
		for (int i = 0; i < 3; i++)
		begin
			wr_reg(`ADDR_BAUD, bauds[i]);
			rd_reg(`ADDR_STATUS, q);
			wr_reg(`ADDR_DATA, ~prev);
			@(posedge ss_n_out);
			repeat (4) @(posedge clk);
			chk(per, divs[i]);
			rd_chk(`ADDR_DATA, prev);
			rd_chk(`ADDR_STATUS, 8'hA0);
			rd_reg(`ADDR_DATA, q);
			prev = ~prev;
		end
		$display("test divisors done");
		irq_chk(1'b0);
		wr_reg(`ADDR_IRQ_MASK, 8'h03);
		irq_chk(1'b1);
		wr_reg(`ADDR_IRQ_STAT, 8'h03);
		irq_chk(1'b0);
		wr_reg(`ADDR_CTRL2, 8'h10);
		wr_reg(`ADDR_CTRL1, 8'hD0);
		@(posedge clk);
		ss_drv <= 1'b0;
		irq_chk(1'b1);
		rd_chk(`ADDR_STATUS, 8'h30);
		rd_reg(`ADDR_CTRL1, q);
		chk({11'h000, q[4] | sck_oe | mosi_oe | miso_oe}, 12'h000);
		@(posedge clk);
		ss_drv <= 1'b1;
		wr_reg(`ADDR_CTRL1, 8'h50);
		rd_chk(`ADDR_STATUS, 8'h20);
		$display("test interrupt and fault done");
		report_and_stop();
	end
endmodule : spi_status_data_baud_tb
